// ---- logic/lwps_pkg.sv ----
// constants shared by the late-write pipelined sram and its controller
// Overview of operation
// R1: register-register read: data one edge later
// R2: late-select: way address picks half next edge
// R3: write address first edge, data next edge
// R4: buffered write commits on the next write
// R5: byte enables timed like write enable
// R6: read address matching buffer returns buffer data
// R7: bypass merges per byte lane
// R8: impedance evaluated every 32 cycles, one step
// R9: impedance changes only while outputs float
// R10: controller waits 1024 non-read cycles after power-up
// R11: protocol select pins fixed from power-up
// R12: sleep ignores inputs, floats outputs, keeps array; the sram still takes write data due at a data edge
// R13: sleep only after buffered write completes
// R14: wait recovery time after sleep ends
// R15: deselect does nothing, outputs float
// R16: late-select only in wide organization
// R17: sleep entry 15 ns, recovery 20 ns
// R18: repeated same-address reads hold outputs steady
// R19: write with no byte enables stores nothing
// R20: read drives all lanes; output enable floats asynchronously
package lwps_pkg;
  localparam int ADDR_W = 19; // double-word address of the wide part
  localparam int NBYTES = 4; // byte lanes of the wide part
  localparam int BYTE_W = 9; // bits per byte lane
  localparam int IMP_W = 6; // impedance code width
  localparam int WIDE = 1; // 1 = wide organization
  localparam int CLK_PERIOD_PS = 10000; // 100 MHz clock
  localparam int IMP_EVAL_CYCLES = 32; // impedance evaluation interval
  localparam int POWERUP_NONREAD_CYCLES = 1024; // non-read cycles after power-up
  localparam int SLEEP_ENTER_NS = 15; // sleep enable time
  localparam int SLEEP_RECOVER_NS = 20; // sleep recovery time
  // least waits round up to whole cycles
  localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLEEP_RECOVER_CYC =
    (SLEEP_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_RSP_STAGES = 3; // issue edge to controller capture
  // protocol select strap codes {high, low}
  localparam logic [1:0] PSEL_REG_REG = 2'h2;
  localparam logic [1:0] PSEL_LATE_SEL = 2'h3;
endpackage

// ---- logic/lwps_if.sv ----
// pin bundle between the sram and its memory controller
`timescale 1ns/1ps
interface lwps_if #(
  parameter int ADDR_W = lwps_pkg::ADDR_W,
  parameter int DATA_W = lwps_pkg::NBYTES * lwps_pkg::BYTE_W,
  parameter int NBYTES = lwps_pkg::NBYTES
);
  logic [ADDR_W-1:0] address_bus; // double-word address
  logic way_select_address; // picks one half of the double word
  logic chip_select_n; // selects the cycle
  logic write_enable_n; // global write enable
  logic [NBYTES-1:0] byte_write_enable_n; // per-lane write enable
  logic output_enable_n; // asynchronous output enable
  logic sleep_request; // asynchronous sleep
  logic protocol_select_low; // static protocol strap
  logic protocol_select_high; // static protocol strap
  logic [DATA_W-1:0] dq_ctrl_out; // controller drive value
  logic dq_ctrl_oe; // controller drives data
  logic [DATA_W-1:0] dq_sram_out; // sram drive value
  logic dq_sram_oe; // sram drives data
  logic [DATA_W-1:0] dq; // resolved shared data wire
  // an undriven wire reads as zero; both driving is a bench fault
  assign dq = dq_sram_oe ? dq_sram_out : (dq_ctrl_oe ? dq_ctrl_out : '0);
  modport sram (
    input address_bus, way_select_address, chip_select_n, write_enable_n,
    input byte_write_enable_n, output_enable_n, sleep_request,
    input protocol_select_low, protocol_select_high, dq,
    output dq_sram_out, dq_sram_oe
  );
  modport ctrl (
    output address_bus, way_select_address, chip_select_n, write_enable_n,
    output byte_write_enable_n, output_enable_n, sleep_request,
    output protocol_select_low, protocol_select_high, dq_ctrl_out, dq_ctrl_oe,
    input dq
  );
endinterface

// ---- logic/lwps_sram.sv ----
// late-write sram core with pipelined and late-select read
`timescale 1ns/1ps
module lwps_sram #(
  parameter int ADDR_W = lwps_pkg::ADDR_W,
  parameter int NBYTES = lwps_pkg::NBYTES,
  parameter int BYTE_W = lwps_pkg::BYTE_W,
  parameter int WIDE = lwps_pkg::WIDE,
  parameter int IMP_W = lwps_pkg::IMP_W
) (
  input wire logic clock,
  input wire logic rst_n,
  lwps_if.sram bus,
  input wire logic [IMP_W-1:0] impedance_target,
  output logic [IMP_W-1:0] impedance_code,
  output logic late_select_active
);
  localparam int DATA_W = NBYTES * BYTE_W;
  localparam int IDX_W = ADDR_W + 1;
  localparam int EVAL_W = $clog2(lwps_pkg::IMP_EVAL_CYCLES);

  // expand byte enables (active high) into a bit mask
  function automatic logic [DATA_W-1:0] lane_mask(input logic [NBYTES-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < NBYTES; i++) begin
      m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
    end
    return m;
  endfunction

  // array: each double word holds two ways, index = {address, way}
  logic [DATA_W-1:0] mem [0:(1<<IDX_W)-1];

  logic awake; // sleep not requested
  logic sel; // selected cycle at this edge
  logic wr_cyc; // write sampled at this edge
  logic rd_cyc; // read sampled at this edge
  logic mode_ls_r; // late-select read active
  logic buf_valid_r; // write buffer holds a write
  logic [IDX_W-1:0] buf_idx_r; // buffered write index
  logic [NBYTES-1:0] buf_be_r; // buffered lanes, active high
  logic [DATA_W-1:0] buf_data_r; // buffered write data
  logic data_due_r; // write data arrives at this edge
  logic [DATA_W-1:0] commit_data; // data committed to the array
  logic rd_pend_r; // read in flight, output at this edge
  logic [ADDR_W-1:0] rd_addr_r; // read address
  logic rd_way_r; // way sampled with the address
  logic [IDX_W-1:0] rd_idx; // final read index
  logic [DATA_W-1:0] rd_word; // merged read word
  logic out_valid_r; // output register holds read data
  logic [DATA_W-1:0] out_data_r; // output register
  logic [EVAL_W-1:0] eval_cnt_r; // impedance evaluation timer
  logic eval_pend_r; // evaluation waiting for a float cycle
  logic [IMP_W-1:0] imp_code_r; // current impedance setting
  logic hiz; // outputs floating this cycle

  // R12: sleep masks every sampled input except write data due at a data edge
  assign awake = ~bus.sleep_request;
  // R15: a deselected edge starts nothing
  assign sel = awake & ~bus.chip_select_n;
  assign wr_cyc = sel & ~bus.write_enable_n;
  assign rd_cyc = sel & bus.write_enable_n;

  // protocol straps caught while reset is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // R16: late-select only exists in the wide organization
      mode_ls_r <= (WIDE != 0) &&
        ({bus.protocol_select_high, bus.protocol_select_low} == lwps_pkg::PSEL_LATE_SEL);
    end
  end

  // write buffer bookkeeping
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_valid_r <= 1'b0;
      buf_idx_r <= '0;
      buf_be_r <= '0;
      data_due_r <= 1'b0;
    end else begin
      data_due_r <= wr_cyc;
      // R3: address, way and controls taken at the first edge
      if (wr_cyc) begin
        buf_valid_r <= 1'b1;
        buf_idx_r <= {bus.address_bus, bus.way_select_address};
        // R5: byte enables sampled with the write enable
        // R19: all enables high leaves an empty buffered write
        buf_be_r <= ~bus.byte_write_enable_n;
      end
    end
  end

  // R3: write data taken one edge after the address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buf_data_r <= '0;
    end else if (data_due_r) begin
      buf_data_r <= bus.dq;
    end
  end

  // back-to-back writes commit before the buffer register has the data
  assign commit_data = data_due_r ? bus.dq : buf_data_r;

  // array commit; contents survive reset and sleep
  always_ff @(posedge clock) begin
    // R4: previous write lands only when the next write arrives
    if (rst_n && wr_cyc && buf_valid_r) begin
      for (int i = 0; i < NBYTES; i++) begin
        if (buf_be_r[i]) begin
          mem[buf_idx_r][i*BYTE_W +: BYTE_W] <= commit_data[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // read address stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      rd_way_r <= 1'b0;
    end else begin
      // R1: address and controls registered at the first edge
      rd_pend_r <= rd_cyc;
      if (rd_cyc) begin
        rd_addr_r <= bus.address_bus;
        rd_way_r <= bus.way_select_address;
      end
    end
  end

  // read word: array data with bypass from the write buffer
  always_comb begin
    // R2: late-select takes the way at the second edge
    rd_idx = mode_ls_r ? {rd_addr_r, bus.way_select_address} : {rd_addr_r, rd_way_r};
    rd_word = mem[rd_idx];
    // R6: matching address returns buffered data at normal latency
    if (buf_valid_r && (buf_idx_r == rd_idx)) begin
      // R7: only the written lanes come from the buffer
      rd_word = (rd_word & ~lane_mask(buf_be_r)) | (buf_data_r & lane_mask(buf_be_r));
    end
  end

  // output register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      // R1: output register loads at the second edge
      out_valid_r <= rd_pend_r & awake;
      // R18: register only reloads on a read, so repeats stay steady
      if (rd_pend_r && awake) begin
        out_data_r <= rd_word;
      end
    end
  end

  // R20: output enable and sleep float the pins without waiting for a clock
  assign bus.dq_sram_oe = out_valid_r & ~bus.output_enable_n & ~bus.sleep_request;
  // R20: a read drives every lane
  assign bus.dq_sram_out = out_data_r;

  // outputs float on write, deselect, sleep or output enable high
  assign hiz = ~(out_valid_r & ~bus.output_enable_n) | bus.sleep_request;

  // impedance evaluation timer, free running
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      eval_cnt_r <= '0;
      eval_pend_r <= 1'b0;
    end else begin
      // R8: one evaluation every 32 cycles
      eval_cnt_r <= eval_cnt_r + 1'b1;
      if (eval_cnt_r == EVAL_W'(lwps_pkg::IMP_EVAL_CYCLES - 1)) begin
        eval_pend_r <= 1'b1;
      end else if (hiz) begin
        eval_pend_r <= 1'b0;
      end
    end
  end

  // impedance stepping; a driving cycle defers the step, it never skips it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      imp_code_r <= '0;
    end else if (eval_pend_r && hiz) begin
      // R9: setting moves only while outputs float
      // R8: at most one step toward the target
      if (imp_code_r < impedance_target) begin
        imp_code_r <= imp_code_r + 1'b1;
      end else if (imp_code_r > impedance_target) begin
        imp_code_r <= imp_code_r - 1'b1;
      end
    end
  end

  assign impedance_code = imp_code_r;
  assign late_select_active = mode_ls_r;
endmodule

// ---- logic/lwps_ctrl.sv ----
// memory controller end driving the late-write sram pins
`timescale 1ns/1ps
module lwps_ctrl #(
  parameter int ADDR_W = lwps_pkg::ADDR_W,
  parameter int NBYTES = lwps_pkg::NBYTES,
  parameter int BYTE_W = lwps_pkg::BYTE_W,
  parameter int LATE_SELECT = 0,
  parameter int POWERUP_CYCLES = lwps_pkg::POWERUP_NONREAD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  lwps_if.ctrl bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_way,
  input wire logic [NBYTES-1:0] req_be,
  input wire logic [NBYTES*BYTE_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [NBYTES*BYTE_W-1:0] rsp_rdata,
  input wire logic sleep_req,
  output logic asleep
);
  localparam int DATA_W = NBYTES * BYTE_W;
  localparam int CNT_W = $clog2(POWERUP_CYCLES + 1);

  typedef enum logic [2:0] {
    lwps_st_powerup, lwps_st_run, lwps_st_flush, lwps_st_enter, lwps_st_sleep,
    lwps_st_wake
  } lwps_state_t;

  lwps_state_t state_r; // controller state
  logic [CNT_W-1:0] cnt_r; // power-up and sleep wait counter
  logic [lwps_pkg::READ_RSP_STAGES-1:0] rd_pipe_r; // reads in flight
  logic way_pend_r; // late-select way for the next edge
  logic wd_pend_r; // write issued, data goes out after the sram samples the address
  logic [DATA_W-1:0] wd_hold_r; // write data waiting for its data cycle
  logic wd_drive_r; // driving write data this cycle
  logic [DATA_W-1:0] wd_r; // write data to drive
  logic wr_block; // a write now would clash with read data
  logic issue; // a request goes out at this edge

  // a write's data cycle must not meet the sram's read drive
  assign wr_block = rd_pipe_r[0] | rd_pipe_r[1];
  assign issue = req_ready & req_valid & ~(req_write & wr_block);

  // R11: protocol straps held constant from reset on
  assign bus.protocol_select_low = (LATE_SELECT != 0) ? lwps_pkg::PSEL_LATE_SEL[0]
                                                      : lwps_pkg::PSEL_REG_REG[0];
  assign bus.protocol_select_high = (LATE_SELECT != 0) ? lwps_pkg::PSEL_LATE_SEL[1]
                                                       : lwps_pkg::PSEL_REG_REG[1];
  // outputs enabled always; floating is left to the command pins and sleep
  assign bus.output_enable_n = 1'b0;

  // sequencing state and wait counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= lwps_st_powerup;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        lwps_st_powerup: begin
          // R10: only non-read cycles until the impedance settles
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(POWERUP_CYCLES - 1)) begin
            state_r <= lwps_st_run;
          end
        end
        lwps_st_run: begin
          if (sleep_req && !req_valid) begin
            state_r <= lwps_st_flush;
          end
        end
        lwps_st_flush: begin
          // R13: empty write pushes out the buffered one
          if (rd_pipe_r == '0 && !wd_drive_r && !wd_pend_r) begin
            state_r <= lwps_st_enter;
            cnt_r <= '0;
          end
        end
        lwps_st_enter: begin
          // data cycle of the flush write is over before sleep rises
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(1)) begin
            state_r <= lwps_st_sleep;
            cnt_r <= '0;
          end
        end
        lwps_st_sleep: begin
          // R17: allow the entry time before leaving again
          if (cnt_r < CNT_W'(lwps_pkg::SLEEP_ENTER_CYC)) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (!sleep_req) begin
            state_r <= lwps_st_wake;
            cnt_r <= '0;
          end
        end
        lwps_st_wake: begin
          // R14: recovery time before normal cycles
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(lwps_pkg::SLEEP_RECOVER_CYC - 1)) begin
            state_r <= lwps_st_run;
          end
        end
      endcase
    end
  end

  // command pins, registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus.chip_select_n <= 1'b1;
      bus.write_enable_n <= 1'b1;
      bus.byte_write_enable_n <= '1;
      bus.address_bus <= '0;
      bus.way_select_address <= 1'b0;
      way_pend_r <= 1'b0;
    end else begin
      bus.chip_select_n <= 1'b1;
      bus.write_enable_n <= 1'b1;
      bus.byte_write_enable_n <= '1;
      // R2: late-select way follows one edge after the address
      if (LATE_SELECT != 0) begin
        bus.way_select_address <= way_pend_r;
      end
      if (issue) begin
        bus.chip_select_n <= 1'b0;
        bus.address_bus <= req_addr;
        // R3: way and controls go out with the address for writes
        if (req_write || LATE_SELECT == 0) begin
          bus.way_select_address <= req_way;
        end
        way_pend_r <= req_way;
        bus.write_enable_n <= ~req_write;
        // R5: byte enables share the write enable's timing
        bus.byte_write_enable_n <= req_write ? ~req_be : '1;
      end else if (state_r == lwps_st_flush && rd_pipe_r == '0 && !wd_drive_r && !wd_pend_r) begin
        // R19: a write with no bytes commits the buffer and stores nothing
        bus.chip_select_n <= 1'b0;
        bus.write_enable_n <= 1'b0;
      end
    end
  end

  // R13: sleep rises only once the flush has landed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus.sleep_request <= 1'b0;
      asleep <= 1'b0;
    end else begin
      bus.sleep_request <= (state_r == lwps_st_enter && cnt_r == CNT_W'(1)) ||
                           (state_r == lwps_st_sleep &&
                            (sleep_req || cnt_r < CNT_W'(lwps_pkg::SLEEP_ENTER_CYC)));
      asleep <= (state_r == lwps_st_sleep);
    end
  end

  // R3: write data driven for the cycle ending at the data edge
  // two stages, so a back-to-back write cannot overwrite data not yet driven
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wd_pend_r <= 1'b0;
      wd_hold_r <= '0;
      wd_drive_r <= 1'b0;
      wd_r <= '0;
    end else begin
      wd_pend_r <= issue & req_write;
      if (issue && req_write) begin
        wd_hold_r <= req_wdata;
      end
      // pins carry the address in the cycle after issue, data one cycle later
      wd_drive_r <= wd_pend_r;
      if (wd_pend_r) begin
        wd_r <= wd_hold_r;
      end
    end
  end

  assign bus.dq_ctrl_oe = wd_drive_r;
  assign bus.dq_ctrl_out = wd_r;

  // read return pipeline
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_pipe_r <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      req_ready <= 1'b0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[lwps_pkg::READ_RSP_STAGES-2:0], issue & ~req_write};
      rsp_valid <= rd_pipe_r[lwps_pkg::READ_RSP_STAGES-1];
      if (rd_pipe_r[lwps_pkg::READ_RSP_STAGES-1]) begin
        rsp_rdata <= bus.dq;
      end
      req_ready <= (state_r == lwps_st_run) && !sleep_req;
    end
  end
endmodule

// ---- verification/lwps_props.sv ----
// concurrent checks on the pins joining the sram and its controller
`timescale 1ns/1ps
module lwps_props #(
  parameter int ADDR_W = lwps_pkg::ADDR_W,
  parameter int DATA_W = lwps_pkg::NBYTES * lwps_pkg::BYTE_W,
  parameter int IMP_W = lwps_pkg::IMP_W,
  parameter int POWERUP_CYCLES = lwps_pkg::POWERUP_NONREAD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic way_select_address,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic protocol_select_low,
  input wire logic protocol_select_high,
  input wire logic dq_ctrl_oe,
  input wire logic dq_sram_oe,
  input wire logic [DATA_W-1:0] dq_sram_out,
  input wire logic [IMP_W-1:0] impedance_code
);
  localparam int IMP_GAP = lwps_pkg::IMP_EVAL_CYCLES - 1; // edges between two steps
  logic [7:0] gap_r; // edges since the last impedance step, saturating
  logic [15:0] nonrd_r; // non-read edges since reset, saturating
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rd_s; !sleep_request && !chip_select_n && write_enable_n; endsequence
  sequence wr_s; !sleep_request && !chip_select_n && !write_enable_n; endsequence
  sequence idle_s; !sleep_request && chip_select_n; endsequence
  // starts saturated so the first step after reset is never flagged
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_r <= 8'hff;
    end else if ($changed(impedance_code)) begin
      gap_r <= 8'h00;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end
  // counts every idle, write and sleep edge, before and after reads; reads are not counted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nonrd_r <= 16'h0000;
    end else if (!(!sleep_request && !chip_select_n && write_enable_n) && nonrd_r != 16'hffff) begin
      nonrd_r <= nonrd_r + 16'h0001;
    end
  end
  a_read_latency: assert property (rd_s |-> ##2 (dq_sram_oe || output_enable_n || sleep_request))
    else $error("read data not driven two edges after the read");
  a_write_float: assert property (wr_s |-> ##2 !dq_sram_oe)
    else $error("sram drives data after a write");
  a_deselect_float: assert property (idle_s |-> ##2 !dq_sram_oe)
    else $error("sram drives data after a deselect");
  a_oe_gate: assert property ((output_enable_n || sleep_request) |-> !dq_sram_oe)
    else $error("sram drives data while disabled or asleep");
  a_no_contention: assert property (!(dq_ctrl_oe && dq_sram_oe))
    else $error("both ends drive the data wire");
  a_same_addr_steady: assert property ((rd_s ##1 (!sleep_request && !chip_select_n && write_enable_n
    && $stable(address_bus) && $stable(way_select_address))) |-> ##2 $stable(dq_sram_out))
    else $error("repeated read of one address changed the output");
  a_imp_one_step: assert property ($changed(impedance_code) |->
    (impedance_code == $past(impedance_code) + 1'b1 || impedance_code + 1'b1 == $past(impedance_code)))
    else $error("impedance moved more than one step");
  a_imp_interval: assert property ($changed(impedance_code) |-> gap_r >= IMP_GAP)
    else $error("impedance stepped sooner than the evaluation interval");
  a_imp_float_only: assert property ($changed(impedance_code) |-> $past(!dq_sram_oe))
    else $error("impedance changed while outputs were driven");
  a_powerup_wait: assert property (rd_s |-> nonrd_r >= POWERUP_CYCLES)
    else $error("read issued before the power-up non-read cycles");
  a_strap_fixed: assert property ($stable({protocol_select_high, protocol_select_low}))
    else $error("protocol straps changed during operation");
endmodule

// ---- verification/late_write_pipelined_sram_tb.sv ----
// bench: controller user side drives the sram across the pin bundle
`timescale 1ns/1ps
module late_write_pipelined_sram_tb;
  localparam int AW = 4; // shrunk array
  localparam int DW = lwps_pkg::NBYTES * lwps_pkg::BYTE_W; // data width
  localparam int PWR = 8; // shortened power-up count
  logic clock = 1'b0;
  logic rst_n = 1'b0; // active low reset
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [AW-1:0] req_addr = '0;
  logic req_way = 1'b0;
  logic [3:0] req_be = 4'h0;
  logic [DW-1:0] req_wdata = '0;
  logic sleep_req = 1'b0;
  logic [5:0] impedance_target = 6'h05; // desired driver code
  logic req_ready, rsp_valid, asleep, late_select_active;
  logic [DW-1:0] rsp_rdata;
  logic [5:0] impedance_code;
  logic [DW-1:0] merged; // lanes 1:0 from the byte write, 3:2 from the full write
  int mismatches = 0;
  int checks_done = 0;
  always #5 clock = ~clock;
  lwps_if #(.ADDR_W(AW)) bus_if ();
  lwps_sram #(.ADDR_W(AW)) i_lwps_sram (.clock(clock), .rst_n(rst_n), .bus(bus_if),
    .impedance_target(impedance_target), .impedance_code(impedance_code),
    .late_select_active(late_select_active));
  lwps_ctrl #(.ADDR_W(AW), .POWERUP_CYCLES(PWR)) i_lwps_ctrl (.clock(clock), .rst_n(rst_n),
    .bus(bus_if), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_way(req_way), .req_be(req_be), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .asleep(asleep));
  lwps_props #(.ADDR_W(AW), .POWERUP_CYCLES(PWR)) i_lwps_props (.clock(clock), .rst_n(rst_n),
    .address_bus(bus_if.address_bus), .way_select_address(bus_if.way_select_address),
    .chip_select_n(bus_if.chip_select_n), .write_enable_n(bus_if.write_enable_n),
    .output_enable_n(bus_if.output_enable_n), .sleep_request(bus_if.sleep_request),
    .protocol_select_low(bus_if.protocol_select_low),
    .protocol_select_high(bus_if.protocol_select_high), .dq_ctrl_oe(bus_if.dq_ctrl_oe),
    .dq_sram_oe(bus_if.dq_sram_oe), .dq_sram_out(bus_if.dq_sram_out),
    .impedance_code(impedance_code));
  // one comparison, counted, reported at once
  task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // valid stays up after the taking edge so requests can run back to back
  task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [3:0] be,
    input logic [DW-1:0] d);
    for (int n = 0; req_ready !== 1'b1 && n < 400; n++) begin
      req_valid = 1'b0;
      @(negedge clock);
    end
    chk("req_ready", 1'b1, req_ready);
    req_write = wr;
    req_addr = a;
    req_be = be;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clock);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [3:0] be, input logic [DW-1:0] d);
    issue(1'b1, a, be, d);
  endtask
  // n reads of one address back to back, then n responses
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input int n);
    for (int i = 0; i < n; i++) issue(1'b0, a, 4'h0, '0);
    req_valid = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; rsp_valid !== 1'b1 && k < 20; k++) @(negedge clock);
      chk("rsp_rdata", exp, rsp_rdata);
      @(negedge clock);
    end
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("mismatch watchdog expected finish seen timeout");
    end_sim();
  end
  initial begin
    merged = {18'(36'h987654321 >> 18), 18'h2bbbb};
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (250) @(negedge clock);
    chk("impedance_code", 6'h05, impedance_code);
    chk("late_select_active", 1'b0, late_select_active);
    wr(4'h0, 4'hf, 36'h123456789);
    wr(4'h1, 4'hf, 36'h987654321);
    wr(4'h1, 4'h3, 36'h0aaa2bbbb);
    rd(4'h1, merged, 1);
    rd(4'h0, 36'h123456789, 2);
    wr(4'h2, 4'h0, 36'h0ffffffff);
    rd(4'h1, merged, 1);
    wr(4'h2, 4'hf, 36'h5a5a5a5a5);
    rd(4'h2, 36'h5a5a5a5a5, 1);
    sleep_req = 1'b1;
    for (int k = 0; asleep !== 1'b1 && k < 50; k++) @(negedge clock);
    repeat (4) @(negedge clock);
    chk("sleep_request", 1'b1, bus_if.sleep_request);
    chk("dq_sram_oe", 1'b0, bus_if.dq_sram_oe);
    sleep_req = 1'b0;
    rd(4'h2, 36'h5a5a5a5a5, 1);
    rd(4'h0, 36'h123456789, 1);
    impedance_target = 6'h03;
    repeat (120) @(negedge clock);
    chk("impedance_code", 6'h03, impedance_code);
    end_sim();
  end
endmodule
